// ---- dv/smbus_slave_pointer_alert_tb_top.sv ----
// Self-checking bench for the SMBus target: host model, register file stub.
// Assumes the design carries its own assertions; timeouts are enabled only in t_timeout.
`timescale 1ns/100ps
module smbus_slave_pointer_alert_tb_top;
    import sps_pkg::*;
    // ********************************************************
    // Wires, design and host
    // ********************************************************
    logic       sys_clk, rstn, alert_cond, status_clear, scl, host_rel, sda;
    logic       sda_en_n, alert_en_n, wr_strobe, ack, rd_strobe, sda_drv, alert_drv, to_en;
    logic [7:0] pointer, wr_data, wr_last, rd, rd_data;
    int         miscompares = 0, n_compared = 0, cyc = 0, wr_cnt = 0, rd_cnt = 0;
    // Open drain with pull-up: low if either party pulls
    assign sda     = host_rel & (sda_en_n | sda_drv);
    assign rd_data = pointer ^ 8'h5A;
    sps_smbus_slave #(.ALT_VARIANT(1'b0), .TIMEOUT_CYC(200)) DUT (
        .SYS_CLK(sys_clk), .RSTN(rstn), .SCL(scl), .SERIAL_DATA_PIN(sda),
        .SERIAL_DATA_PIN_DRV(sda_drv), .SERIAL_DATA_PIN_EN_N(sda_en_n),
        .ALERT_PIN_DRV(alert_drv), .ALERT_PIN_EN_N(alert_en_n),
        .ALERT_COND(alert_cond), .STATUS_CLEAR(status_clear),
        .SCL_TO_EN(to_en), .SDA_TO_EN(to_en), .POINTER(pointer), .WR_DATA(wr_data),
        .WR_STROBE(wr_strobe), .RD_STROBE(rd_strobe), .RD_DATA(rd_data));
    sps_host_model u_host (.scl(scl), .sda_rel(host_rel), .sda(sda));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Ceiling far above the few thousand cycles of traffic
    always @(posedge sys_clk) begin
        cyc++;
        if (wr_strobe === 1'b1) begin
            wr_cnt++;
            wr_last = wr_data;
        end
        if (rd_strobe === 1'b1) begin
            rd_cnt++;
        end
        if (cyc == 20000) begin
            miscompares++;
            results();
        end
    end
    // ********************************************************
    // Helpers and scenarios
    // ********************************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Checksum over one byte, MSB first, no reflection
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8
    task automatic put(input string what, input logic [7:0] b, input logic seen_exp);
        u_host.xfer(b, 1'b1, rd, ack);
        chk(what, {7'h00, seen_exp}, {7'h00, ack});
    endtask : put
    task automatic get(input logic [6:0] a, input logic [7:0] exp);
        u_host.start();
        put("read addr ack", {a, 1'b1}, 1'b0);
        u_host.xfer(8'hFF, 1'b1, rd, ack);
        chk("read byte", exp, rd);
        u_host.stop();
    endtask : get
    task automatic alert_is(input string what, input logic lvl);
        for (int i = 0; i < 20 && alert_en_n !== lvl; i++) begin
            @(posedge sys_clk);
        end
        chk(what, {7'h00, lvl}, {7'h00, alert_en_n});
    endtask : alert_is
    task automatic t_reset();
        repeat (3) @(posedge sys_clk);
        chk("pointer reset", PTR_RST, pointer);
        chk("data released", 8'h01, {7'h00, sda_en_n});
        chk("alert released", 8'h01, {7'h00, alert_en_n});
        chk("drive levels", 8'h00, {6'h00, sda_drv, alert_drv});
    endtask : t_reset
    task automatic t_write();
        int n0;
        logic [7:0] pec;
        n0 = wr_cnt;
        pec = crc8(crc8(crc8(CRC_RST, {OWN_ADDR_STD, 1'b0}), 8'h05), 8'hAA);
        u_host.start();
        put("own addr ack", {OWN_ADDR_STD, 1'b0}, 1'b0);
        put("ptr ack", 8'h05, 1'b0);
        chk("pointer", 8'h05, pointer);
        put("data ack", 8'hAA, 1'b0);
        put("pec ack", pec, 1'b0);
        u_host.stop();
        chk("write count", 8'h01, 8'(wr_cnt - n0));
        chk("write data", 8'hAA, wr_last);
    endtask : t_write
    task automatic t_read();
        int r0;
        r0 = rd_cnt;
        u_host.start();
        put("ptr addr ack", {OWN_ADDR_STD, 1'b0}, 1'b0);
        put("ptr only ack", 8'h3D, 1'b0);
        u_host.stop();
        chk("pointer moved", 8'h3D, pointer);
        get(OWN_ADDR_STD, 8'h3D ^ 8'h5A);
        get(OWN_ADDR_STD, 8'h3D ^ 8'h5A);
        chk("read strobes", 8'h02, 8'(rd_cnt - r0));
    endtask : t_read
    task automatic t_foreign();
        u_host.start();
        put("foreign nack", {OWN_ADDR_ALT, 1'b0}, 1'b1);
        put("ignored byte", 8'h07, 1'b1);
        u_host.stop();
        chk("pointer kept", 8'h3D, pointer);
    endtask : t_foreign
    task automatic t_timeout();
        @(posedge sys_clk) #1 to_en = 1'b1;
        u_host.start();
        put("to addr ack", {OWN_ADDR_STD, 1'b0}, 1'b0);
        u_host.hold_low(2500);
        put("to abandoned", 8'h11, 1'b1);
        u_host.stop();
        chk("to pointer kept", 8'h3D, pointer);
        @(posedge sys_clk) #1 to_en = 1'b0;
    endtask : t_timeout
    task automatic t_alert();
        @(posedge sys_clk) #1 alert_cond = 1'b1;
        alert_is("alert on", 1'b0);
        u_host.start();
        put("ara lost ack", {ARA_ADDR, 1'b1}, 1'b0);
        u_host.xfer({OWN_ADDR_ALT, 1'b1}, 1'b1, rd, ack);
        chk("arb lost byte", {OWN_ADDR_ALT, 1'b1}, rd);
        u_host.stop();
        get(ARA_ADDR, {OWN_ADDR_STD, 1'b1});
        repeat (20) @(posedge sys_clk);
        alert_is("alert held", 1'b0);
        @(posedge sys_clk) #1 alert_cond = 1'b0;
        repeat (20) @(posedge sys_clk);
        alert_is("alert uncleared", 1'b0);
        @(posedge sys_clk) #1 status_clear = 1'b1;
        alert_is("alert off", 1'b1);
        u_host.start();
        put("ara unanswered", {ARA_ADDR, 1'b1}, 1'b1);
        u_host.stop();
    endtask : t_alert
    task automatic results();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    initial begin
        rstn         = 1'b0;
        alert_cond   = 1'b0;
        status_clear = 1'b0;
        to_en        = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 rstn = 1'b1;
        t_reset();
        t_write();
        t_read();
        t_foreign();
        t_timeout();
        t_alert();
        results();
    end
endmodule : smbus_slave_pointer_alert_tb_top

// ---- dv/sps_host_model.sv ----
// Host side of the SMBus: drives the bus clock and pulls or releases data.
// Assumes the bench resolves the data wire with a pull-up from all enables.
`timescale 1ns/100ps
module sps_host_model (
    // Bus wires
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda
);
    // ********************************************************
    // Bus sequences; the clock stands high between frames
    // ********************************************************
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end
    // Data falls while the clock is high
    task automatic start();
        #31 sda_rel = 1'b0;
        #32;
    endtask : start
    // Data moves mid-low, holds through high, sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        scl = 1'b0;
        #31 sda_rel = b;
        #31 scl = 1'b1;
        #31 s = sda;
        #32;
    endtask : bit_io
    // Eight bits MSB first, then the ninth: released for ack, or our ack/no-ack
    task automatic xfer(input logic [7:0] wd, input logic ninth,
                        output logic [7:0] rd, output logic seen);
        for (int i = 7; i >= 0; i--) begin
            bit_io(wd[i], rd[i]);
        end
        bit_io(ninth, seen);
    endtask : xfer
    // Clock held low to stall the bus
    task automatic hold_low(input int ns);
        scl = 1'b0;
        #(ns);
    endtask : hold_low
    // Data low in the low phase, rises while the tenth clock is high
    task automatic stop();
        scl = 1'b0;
        #31 sda_rel = 1'b0;
        #31 scl = 1'b1;
        #31 sda_rel = 1'b1;
        #32;
    endtask : stop
endmodule : sps_host_model

// ---- logic/sps_pkg.sv ----
// Constants and types shared by the SMBus target with pointer and alert.
// Assumes a 100 MHz system clock; no other file is needed.
package sps_pkg;

    // ********************************************************
    // Addresses on the bus
    // ********************************************************
    localparam logic [6:0] OWN_ADDR_STD = 7'h4C;
    localparam logic [6:0] OWN_ADDR_ALT = 7'h4B;
    localparam logic [6:0] ARA_ADDR     = 7'h0C;

    // ********************************************************
    // Framing and checksum
    // ********************************************************
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] CRC_POLY      = 8'h07;
    localparam logic [7:0] CRC_RST       = 8'h00;
    localparam logic [7:0] PTR_RST       = 8'h00;
    localparam logic [7:0] BYTE_RST      = 8'h00;
    localparam logic [7:0] TX_IDLE       = 8'hFF;

    // ********************************************************
    // Bus inactivity timeout
    // ********************************************************
    localparam int TIMEOUT_MS      = 25;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int TIMEOUT_CYC_DEF = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TO_CNT_W        = 22;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0] {
        S_IDLE,
        S_RX,
        S_ACK,
        S_TX,
        S_MACK,
        S_IGN
    } sps_state_t;

    typedef enum logic [2:0] {
        K_ADDR,
        K_PTR,
        K_DATA,
        K_PEC,
        K_END
    } sps_kind_t;

endpackage : sps_pkg

// ---- logic/sps_smbus_slave.sv ----
// SMBus target: address match, pointer load, one-byte register access,
// optional checksum byte, bus timeout and the alert pin with its response.
// Assumes bus pins come from outside the clock domain and that the register
// file outside presents RD_DATA for POINTER and accepts WR_STROBE.
//
// Function
// - Answer only the fixed own address, 0x4C, or 0x4B for the alternate, and the ARA 0x0C while alerting.
// - Shift in seven address bits, most significant first, then direction.
// - On own address, pull data low in the low before ninth pulse.
// - Direction 0 means master writes; direction 1 means master reads.
// - Every byte is eight data pulses plus one acknowledge pulse.
// - Data changes only in clock low; rising data at clock high is stop.
// - Direction is fixed by the address byte until a new start.
// - Accept one or two write bytes; supply exactly one read byte.
// - First write byte always loads the pointer.
// - A second write byte is stored to the register the pointer selects.
// - A read returns the register selected by the present pointer.
// - Master loads write or read pointer values before each access.
// - Pull the open-drain alert low on a limit fault or open sensor.
// - While alerting, acknowledge that address and return own address, LSB 1.
// - Arbitrate bitwise on the response; on loss stop driving.
// - After answering, release alert only once the cause has ended.
// - Optional clock and data timeouts abandon a transfer after 25 ms.
// - Extra byte after the transfer is a CRC-8 checksum, poly 0x07.
// - Alert also stays asserted until the status register is cleared.
`timescale 1ns/100ps
module sps_smbus_slave #(
    parameter bit ALT_VARIANT = 1'b0,
    parameter int TIMEOUT_CYC = sps_pkg::TIMEOUT_CYC_DEF
) (
    // Clock and reset
    input  wire logic       SYS_CLK,
    input  wire logic       RSTN,
    // Bus clock and data pins
    input  wire logic       SCL,
    input  wire logic       SERIAL_DATA_PIN,
    output logic            SERIAL_DATA_PIN_DRV,
    output logic            SERIAL_DATA_PIN_EN_N,
    // Alert pin
    output logic            ALERT_PIN_DRV,
    output logic            ALERT_PIN_EN_N,
    // Alert sources from the monitor
    input  wire logic       ALERT_COND,
    input  wire logic       STATUS_CLEAR,
    // Timeout enables
    input  wire logic       SCL_TO_EN,
    input  wire logic       SDA_TO_EN,
    // Register file side
    output logic [7:0]      POINTER,
    output logic [7:0]      WR_DATA,
    output logic            WR_STROBE,
    output logic            RD_STROBE,
    input  wire logic [7:0] RD_DATA
);
    import sps_pkg::*;

    localparam logic [6:0] OWN_ADDR = ALT_VARIANT ? OWN_ADDR_ALT : OWN_ADDR_STD;
    localparam logic [TO_CNT_W-1:0] TO_LAST = TO_CNT_W'(TIMEOUT_CYC - 1);

    // ********************************************************
    // Pin sampling
    // ********************************************************
    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;

    sps_sync u_scl_sync (
        .clk   (SYS_CLK),
        .rstn  (RSTN),
        .din   (SCL),
        .level (scl_lvl),
        .rise  (scl_rise),
        .fall  (scl_fall)
    );

    sps_sync u_sda_sync (
        .clk   (SYS_CLK),
        .rstn  (RSTN),
        .din   (SERIAL_DATA_PIN),
        .level (sda_lvl),
        .rise  (sda_rise),
        .fall  (sda_fall)
    );

    // ********************************************************
    // State and decode
    // ********************************************************
    sps_state_t          state_ff;
    sps_kind_t           kind_ff;
    logic [3:0]          cnt_ff;
    logic [7:0]          shreg_ff;
    logic [7:0]          tx_ff;
    logic [7:0]          crc_ff;
    logic                read_ff;
    logic                ara_ff;
    logic                mack_ff;
    logic                drive_ff;
    logic [7:0]          ptr_ff;
    logic [7:0]          wr_data_ff;
    logic                wr_stb_ff;
    logic                rd_stb_ff;
    logic                alert_ff;
    logic                served_ff;
    logic [TO_CNT_W-1:0] scl_to_ff;
    logic [TO_CNT_W-1:0] sda_to_ff;

    logic start_evt;
    logic stop_evt;
    logic byte_end;
    logic addr_own;
    logic addr_ara;
    logic lost;
    logic tx_end;
    logic to_hit;

    // Start and stop are the only legal data moves while clock is high
    assign start_evt = sda_fall & scl_lvl;
    assign stop_evt  = sda_rise & scl_lvl;
    assign byte_end  = (state_ff == S_RX) & scl_fall & (cnt_ff == BITS_PER_BYTE);
    assign addr_own  = shreg_ff[7:1] == OWN_ADDR;
    assign addr_ara  = (shreg_ff[7:1] == ARA_ADDR) & shreg_ff[0] & alert_ff;
    // A released one seen low means a lower address is winning
    assign lost      = (state_ff == S_TX) & scl_rise & tx_ff[7] & ~sda_lvl;
    assign tx_end    = (state_ff == S_TX) & scl_fall & (cnt_ff == BITS_PER_BYTE);
    assign to_hit    = (scl_to_ff == TO_LAST) | (sda_to_ff == TO_LAST);

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[7] ^ b;
        crc_step = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : CRC_RST);
    endfunction : crc_step

    // ********************************************************
    // Byte sequencer
    // ********************************************************
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_ff <= S_IDLE;
            kind_ff  <= K_ADDR;
            cnt_ff   <= 4'h0;
            read_ff  <= 1'b0;
            ara_ff   <= 1'b0;
            mack_ff  <= 1'b0;
        end else if (start_evt) begin
            // A repeated start may switch direction; nothing else can
            state_ff <= S_RX;
            kind_ff  <= K_ADDR;
            cnt_ff   <= 4'h0;
            read_ff  <= 1'b0;
            ara_ff   <= 1'b0;
        end else if (stop_evt || to_hit) begin
            state_ff <= S_IDLE;
        end else begin
            unique case (state_ff)
                S_IDLE, S_IGN: begin
                end
                S_RX: begin
                    if (scl_rise) begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end else if (byte_end) begin
                        cnt_ff <= 4'h0;
                        unique case (kind_ff)
                            K_ADDR: begin
                                if (addr_own) begin
                                    state_ff <= S_ACK;
                                    read_ff  <= shreg_ff[0];
                                    kind_ff  <= shreg_ff[0] ? K_DATA : K_PTR;
                                end else if (addr_ara) begin
                                    state_ff <= S_ACK;
                                    read_ff  <= 1'b1;
                                    ara_ff   <= 1'b1;
                                    kind_ff  <= K_DATA;
                                end else begin
                                    state_ff <= S_IGN;
                                end
                            end
                            K_PTR: begin
                                state_ff <= S_ACK;
                                kind_ff  <= K_DATA;
                            end
                            K_DATA: begin
                                state_ff <= S_ACK;
                                kind_ff  <= K_PEC;
                            end
                            K_PEC: begin
                                // Remainder is zero once a good checksum is shifted in
                                state_ff <= (crc_ff == CRC_RST) ? S_ACK : S_IGN;
                                kind_ff  <= K_END;
                            end
                            K_END: begin
                                state_ff <= S_IGN;
                            end
                        endcase
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        state_ff <= read_ff ? S_TX : S_RX;
                    end
                end
                S_TX: begin
                    if (lost) begin
                        state_ff <= S_IGN;
                    end else if (scl_rise) begin
                        cnt_ff <= cnt_ff + 4'h1;
                    end else if (tx_end) begin
                        state_ff <= S_MACK;
                        cnt_ff   <= 4'h0;
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        mack_ff <= ~sda_lvl;
                    end else if (scl_fall) begin
                        if (mack_ff && kind_ff == K_DATA) begin
                            state_ff <= S_TX;
                            kind_ff  <= K_PEC;
                        end else begin
                            state_ff <= S_IGN;
                        end
                    end
                end
            endcase
        end
    end

    // ********************************************************
    // Shift registers and checksum
    // ********************************************************
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            shreg_ff <= BYTE_RST;
            tx_ff    <= TX_IDLE;
            crc_ff   <= CRC_RST;
        end else if (start_evt || stop_evt || to_hit) begin
            // Checksum spans the whole transfer from the first address byte
            shreg_ff <= BYTE_RST;
            tx_ff    <= TX_IDLE;
            if (state_ff == S_IDLE || !start_evt) begin
                crc_ff <= CRC_RST;
            end
        end else if (state_ff == S_RX && scl_rise) begin
            shreg_ff <= {shreg_ff[6:0], sda_lvl};
            crc_ff   <= crc_step(crc_ff, sda_lvl);
        end else if (state_ff == S_TX && scl_rise) begin
            crc_ff <= crc_step(crc_ff, tx_ff[7]);
        end else if (state_ff == S_TX && scl_fall) begin
            tx_ff <= {tx_ff[6:0], 1'b1};
        end else if (state_ff == S_ACK && scl_fall && read_ff) begin
            tx_ff <= ara_ff ? {OWN_ADDR, 1'b1} : RD_DATA;
        end else if (state_ff == S_MACK && scl_fall && mack_ff && kind_ff == K_DATA) begin
            tx_ff <= crc_ff;
        end
    end

    // ********************************************************
    // Data pin drive
    // ********************************************************
    // One cycle behind the sequencer; still far inside the clock-low phase
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            drive_ff <= 1'b0;
        end else begin
            drive_ff <= (state_ff == S_ACK) | ((state_ff == S_TX) & ~tx_ff[7]);
        end
    end

    assign SERIAL_DATA_PIN_DRV  = 1'b0;
    assign SERIAL_DATA_PIN_EN_N = ~drive_ff;

    // ********************************************************
    // Pointer and register strobes
    // ********************************************************
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ptr_ff     <= PTR_RST;
            wr_data_ff <= BYTE_RST;
            wr_stb_ff  <= 1'b0;
            rd_stb_ff  <= 1'b0;
        end else begin
            wr_stb_ff <= 1'b0;
            rd_stb_ff <= 1'b0;
            if (byte_end && kind_ff == K_PTR) begin
                ptr_ff <= shreg_ff;
            end
            if (byte_end && kind_ff == K_DATA) begin
                wr_data_ff <= shreg_ff;
                wr_stb_ff  <= 1'b1;
            end
            if (state_ff == S_ACK && scl_fall && read_ff && !ara_ff) begin
                rd_stb_ff <= 1'b1;
            end
        end
    end

    assign POINTER   = ptr_ff;
    assign WR_DATA   = wr_data_ff;
    assign WR_STROBE = wr_stb_ff;
    assign RD_STROBE = rd_stb_ff;

    // ********************************************************
    // Alert pin
    // ********************************************************
    // A live cause always wins over the release
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            alert_ff <= 1'b0;
        end else if (ALERT_COND) begin
            alert_ff <= 1'b1;
        end else if (served_ff && STATUS_CLEAR) begin
            alert_ff <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            served_ff <= 1'b0;
        end else if (tx_end && ara_ff && kind_ff == K_DATA) begin
            served_ff <= 1'b1;
        end else if (!alert_ff) begin
            served_ff <= 1'b0;
        end
    end

    assign ALERT_PIN_DRV  = 1'b0;
    assign ALERT_PIN_EN_N = ~alert_ff;

    // ********************************************************
    // Bus timeouts
    // ********************************************************
    // Both idle when disabled; enables are plain inputs held low after reset
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            scl_to_ff <= '0;
        end else if (SCL_TO_EN && state_ff != S_IDLE && !scl_lvl && !to_hit) begin
            scl_to_ff <= scl_to_ff + 1'b1;
        end else begin
            scl_to_ff <= '0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sda_to_ff <= '0;
        end else if (SDA_TO_EN && state_ff != S_IDLE && !sda_lvl && !to_hit) begin
            sda_to_ff <= sda_to_ff + 1'b1;
        end else begin
            sda_to_ff <= '0;
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    a_addr_ack_drive: assert property (
        byte_end && kind_ff == K_ADDR && addr_own && !start_evt && !stop_evt && !to_hit
        |-> ##2 drive_ff [*2])
        else $error("own address not acknowledged");

    a_foreign_quiet: assert property (
        byte_end && kind_ff == K_ADDR && !addr_own && !addr_ara && !start_evt
        && !stop_evt && !to_hit |=> (state_ff == S_IGN) ##1 !drive_ff)
        else $error("foreign address not ignored");

    a_pointer_load: assert property (
        byte_end && kind_ff == K_PTR && !start_evt && !stop_evt && !to_hit
        |=> POINTER == $past(shreg_ff))
        else $error("pointer not loaded from first write byte");

    a_write_data: assert property (
        WR_STROBE |-> WR_DATA == $past(shreg_ff) && !$past(WR_STROBE))
        else $error("write strobe without matching data");

    a_alert_follows: assert property (
        ALERT_COND |=> !ALERT_PIN_EN_N)
        else $error("alert not driven on a live cause");

    a_alert_release: assert property (
        $fell(alert_ff) |-> $past(served_ff) && $past(STATUS_CLEAR) && !$past(ALERT_COND))
        else $error("alert released too early");

    a_arb_release: assert property (
        lost && !start_evt && !stop_evt && !to_hit |-> ##2 !drive_ff)
        else $error("data pin still driven after lost arbitration");

    a_stop_idle: assert property (
        stop_evt && !start_evt |=> state_ff == S_IDLE ##1 !drive_ff)
        else $error("stop did not end the transfer");

    a_timeout_idle: assert property (
        to_hit && !start_evt |=> state_ff == S_IDLE)
        else $error("timeout did not abandon the transfer");

    c_pointer_write: cover property (byte_end && kind_ff == K_PTR);
    c_data_write: cover property (WR_STROBE);
    c_register_read: cover property (RD_STROBE);
    c_alert_served: cover property ($rose(served_ff));

endmodule : sps_smbus_slave

// ---- logic/sps_sync.sv ----
// Two-flop synchroniser with edge detection for one bus pin.
// Assumes the pin is asynchronous to clk; edges are one-cycle pulses.
`timescale 1ns/100ps
module sps_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Pin and its sampled view
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // Pin idles high on an open-drain bus, so reset to high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            prev_ff <= 1'b1;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise  = sync_ff & ~prev_ff;
    assign fall  = ~sync_ff & prev_ff;

endmodule : sps_sync
